//--- core/cfec_cnt_if.sv
// Carrier between the top and one diagnostics counter
`timescale 1ns/1ns
interface cfec_cnt_if #(parameter int unsigned W = 8);
    logic inc;
    logic clr;
    logic [W-1:0] val;
    modport owner (input inc, input clr, output val);
    modport user (output inc, output clr, input val);
endinterface

//--- core/cfec_pkg.sv
// Shared constants for the fault-confinement status block
package cfec_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned TEC_W = 9;
    // Register byte offsets
    localparam logic [11:0] OFF_TXQ_PTR = 12'h000;
    localparam logic [11:0] OFF_FAULT = 12'h004;
    localparam logic [11:0] OFF_DIAG = 12'h008;
    localparam logic [11:0] OFF_CTRL = 12'h00C;
    localparam logic [11:0] OFF_FLAGS = 12'h010;
    // Fault register fields
    localparam int unsigned BIT_BUS_OFF = 21;
    localparam int unsigned BIT_TX_PASSIVE = 20;
    localparam int unsigned BIT_RX_PASSIVE = 19;
    localparam int unsigned BIT_TX_WARN = 18;
    localparam int unsigned BIT_RX_WARN = 17;
    localparam int unsigned BIT_ANY_WARN = 16;
    localparam int unsigned TEC_LSB = 8;
    localparam int unsigned REC_LSB = 0;
    // Diagnostics register fields
    localparam int unsigned DAT_TX_LSB = 24;
    localparam int unsigned DAT_RX_LSB = 16;
    localparam int unsigned NOM_TX_LSB = 8;
    localparam int unsigned NOM_RX_LSB = 0;
    // Control and flag register fields
    localparam int unsigned BIT_CFG_MODE = 0;
    localparam int unsigned BIT_PTR_INCR = 1;
    localparam int unsigned BIT_ERR_IRQ = 0;
    localparam int unsigned BIT_B0_RECOV = 1;
    // Thresholds
    localparam logic [8:0] TEC_BUS_OFF_LIM = 9'h0FF;
    localparam logic [8:0] PASSIVE_LIM = 9'h07F;
    localparam logic [8:0] WARN_LO = 9'h05F;
    localparam logic [8:0] WARN_HI = 9'h080;
    localparam logic [7:0] CNT_MAX = 8'hFF;
    localparam logic [3:0] RECESS_RUN = 4'hB;
    localparam logic CFG_MODE_RST = 1'b1;
    // Diagnostics counter slots
    localparam int unsigned SLOT_NOM_RX = 0;
    localparam int unsigned SLOT_NOM_TX = 1;
    localparam int unsigned SLOT_DAT_RX = 2;
    localparam int unsigned SLOT_DAT_TX = 3;
    localparam int unsigned N_SLOTS = 4;
    typedef enum logic [1:0] {
        CFEC_ACTIVE = 2'b01,
        CFEC_BUS_OFF = 2'b10
    } cfec_conf_e;
endpackage

//--- core/cfec_sat_cnt.sv
// Saturating count-up diagnostics counter with clear
`timescale 1ns/1ns
module cfec_sat_cnt #(
    parameter int unsigned W = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    cfec_cnt_if.owner cnt
);
    typedef struct packed {
        logic [W-1:0] val;
    } cfec_cnt_s;
    localparam logic [W-1:0] MAXV = {W{1'b1}};
    localparam logic [W-1:0] ONE = W'(1);
    cfec_cnt_s s_q;
    cfec_cnt_s s_d;

    always_comb begin
        s_d = s_q;
        if (cnt.clr) begin
            s_d.val = cnt.inc ? ONE : '0;
        end else if (cnt.inc && s_q.val != MAXV) begin
            s_d.val = s_q.val + ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cnt.val = s_q.val;

    property p_sat_hold;
        @(posedge clk_i) disable iff (!rstn_i)
        (s_q.val == MAXV && !cnt.clr) |=> (s_q.val == MAXV);
    endproperty
    a_sat_hold: assert property (p_sat_hold)
        else $error("diag counter left saturation");

    property p_no_down;
        @(posedge clk_i) disable iff (!rstn_i)
        !cnt.clr |=> (s_q.val >= $past(s_q.val));
    endproperty
    a_no_down: assert property (p_no_down)
        else $error("diag counter counted down");

    property p_inc_one;
        @(posedge clk_i) disable iff (!rstn_i)
        (cnt.inc && !cnt.clr && s_q.val != MAXV)
            |=> (s_q.val == $past(s_q.val) + ONE);
    endproperty
    a_inc_one: assert property (p_inc_one)
        else $error("diag counter did not add one");
endmodule

//--- core/cfec_top.sv
// Fault-confinement status, diagnostics and queue pointer over APB
// Contract
// - Queue pointer read returns next write address
// - Pointer is message RAM byte address
// - Increment request advances queue head element; ignored in config mode
// - Bus-off bit reads set in config mode
// - Transmit count above 255 enters bus-off; not entered in config mode
// - Bus-off entry sets error flag, starts recovery
// - Transmit passive bit when count above 127
// - Receive passive bit when count above 127
// - Transmit warning when count 96 to 127
// - Receive warning when count 96 to 127
// - Any-warning bit ORs both warnings
// - Transmit count in bits 15 to 8
// - Receive count in bits 7 to 0
// - Four 8-bit phase counters in diagnostics word
// - Diagnostics counter adds one per error
// - Diagnostics counters never count down
// - Diagnostics read returns then clears counters
// - Flag each 11 recessive bits during recovery
`timescale 1ns/1ns
module cfec_top #(
    parameter logic [31:0] TXQ_BASE = 32'h0000_0000,
    parameter logic [31:0] ELEM_BYTES = 32'h0000_0010,
    parameter int unsigned TXQ_DEPTH = 8,
    parameter logic [7:0] RECOVERY_SEQS = 8'h80
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cfec_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [cfec_pkg::DATA_W-1:0] pwdata_i,
    output logic [cfec_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [cfec_pkg::TEC_W-1:0] tx_error_count_i,
    input wire logic [cfec_pkg::CNT_W-1:0] rx_error_count_i,
    input wire logic bit_tick_i,
    input wire logic bus_recessive_i,
    input wire logic nom_tx_err_i,
    input wire logic nom_rx_err_i,
    input wire logic dat_tx_err_i,
    input wire logic dat_rx_err_i,
    output logic config_mode_o,
    output logic bus_off_o,
    output logic bus_error_irq_flag_o,
    output logic recovery_done_o,
    output logic pointer_increment_o
);
    localparam int unsigned QW = (TXQ_DEPTH > 1) ? $clog2(TXQ_DEPTH) : 1;
    localparam logic [QW-1:0] QLAST = QW'(TXQ_DEPTH - 1);
    localparam logic [QW-1:0] QONE = QW'(1);

    typedef struct packed {
        cfec_pkg::cfec_conf_e st;
        logic cfg;
        logic [QW-1:0] qidx;
        logic irq;
        logic b0;
        logic [3:0] run;
        logic [7:0] seqs;
        logic done;
        logic incr;
        logic rdy;
        logic err;
        logic [31:0] rdata;
    } cfec_top_s;

    cfec_top_s s_q;
    cfec_top_s s_d;
    cfec_cnt_if #(.W(cfec_pkg::CNT_W)) cnt_if [cfec_pkg::N_SLOTS] ();

    logic acc;
    logic rd;
    logic wr;
    logic hit;
    logic enter_bo;
    logic seq_done;
    logic tx_pas;
    logic rx_pas;
    logic tx_warn;
    logic rx_warn;
    logic [7:0] tec8;
    logic [8:0] rec9;
    logic [31:0] fault_w;
    logic [31:0] diag_w;
    logic [31:0] qaddr;
    logic [3:0] err_in;

    assign err_in[cfec_pkg::SLOT_NOM_RX] = nom_rx_err_i;
    assign err_in[cfec_pkg::SLOT_NOM_TX] = nom_tx_err_i;
    assign err_in[cfec_pkg::SLOT_DAT_RX] = dat_rx_err_i;
    assign err_in[cfec_pkg::SLOT_DAT_TX] = dat_tx_err_i;

    // Access cycle in which the answer is prepared
    assign acc = psel_i && penable_i && !s_q.rdy;
    assign rd = acc && !pwrite_i;
    assign wr = acc && pwrite_i;

    genvar g;
    generate
        for (g = 0; g < cfec_pkg::N_SLOTS; g++) begin : g_diag
            assign cnt_if[g].inc = err_in[g];
            assign cnt_if[g].clr = rd && paddr_i == cfec_pkg::OFF_DIAG;
            cfec_sat_cnt #(.W(cfec_pkg::CNT_W)) u_cnt (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .cnt(cnt_if[g])
            );
        end
    endgenerate

    // Status decode from confinement counts
    assign rec9 = {1'b0, rx_error_count_i};
    assign tx_pas = tx_error_count_i > cfec_pkg::PASSIVE_LIM;
    assign rx_pas = rec9 > cfec_pkg::PASSIVE_LIM;
    assign tx_warn = tx_error_count_i > cfec_pkg::WARN_LO &&
        tx_error_count_i < cfec_pkg::WARN_HI;
    assign rx_warn = rec9 > cfec_pkg::WARN_LO &&
        rec9 < cfec_pkg::WARN_HI;
    assign tec8 = tx_error_count_i[8] ? cfec_pkg::CNT_MAX
        : tx_error_count_i[7:0];
    assign enter_bo = s_q.st == cfec_pkg::CFEC_ACTIVE && !s_q.cfg &&
        tx_error_count_i > cfec_pkg::TEC_BUS_OFF_LIM;
    assign seq_done = s_q.run == cfec_pkg::RECESS_RUN - 4'h1;

    always_comb begin
        fault_w = '0;
        fault_w[cfec_pkg::BIT_BUS_OFF] = s_q.cfg ||
            s_q.st == cfec_pkg::CFEC_BUS_OFF ||
            tx_error_count_i > cfec_pkg::TEC_BUS_OFF_LIM;
        fault_w[cfec_pkg::BIT_TX_PASSIVE] = tx_pas;
        fault_w[cfec_pkg::BIT_RX_PASSIVE] = rx_pas;
        fault_w[cfec_pkg::BIT_TX_WARN] = tx_warn;
        fault_w[cfec_pkg::BIT_RX_WARN] = rx_warn;
        fault_w[cfec_pkg::BIT_ANY_WARN] = tx_warn || rx_warn;
        fault_w[cfec_pkg::TEC_LSB +: 8] = tec8;
        fault_w[cfec_pkg::REC_LSB +: 8] = rx_error_count_i;
    end

    always_comb begin
        diag_w = '0;
        diag_w[cfec_pkg::DAT_TX_LSB +: 8] =
            cnt_if[cfec_pkg::SLOT_DAT_TX].val;
        diag_w[cfec_pkg::DAT_RX_LSB +: 8] =
            cnt_if[cfec_pkg::SLOT_DAT_RX].val;
        diag_w[cfec_pkg::NOM_TX_LSB +: 8] =
            cnt_if[cfec_pkg::SLOT_NOM_TX].val;
        diag_w[cfec_pkg::NOM_RX_LSB +: 8] =
            cnt_if[cfec_pkg::SLOT_NOM_RX].val;
    end

    // Byte address of the queue head in message RAM
    assign qaddr = TXQ_BASE + 32'(32'(s_q.qidx) * ELEM_BYTES);

    always_comb begin
        s_d = s_q;
        s_d.rdy = acc;
        s_d.done = 1'b0;
        s_d.incr = 1'b0;
        hit = 1'b1;
        // Register read and write decode
        if (acc) begin
            s_d.err = 1'b0;
            s_d.rdata = '0;
            unique case (paddr_i)
                cfec_pkg::OFF_TXQ_PTR: begin
                    s_d.rdata = qaddr;
                end
                cfec_pkg::OFF_FAULT: begin
                    s_d.rdata = fault_w;
                end
                cfec_pkg::OFF_DIAG: begin
                    s_d.rdata = diag_w;
                end
                cfec_pkg::OFF_CTRL: begin
                    s_d.rdata[cfec_pkg::BIT_CFG_MODE] = s_q.cfg;
                    if (wr) begin
                        s_d.cfg = pwdata_i[cfec_pkg::BIT_CFG_MODE];
                        s_d.incr = pwdata_i[cfec_pkg::BIT_PTR_INCR] &&
                            !s_q.cfg;
                    end
                end
                cfec_pkg::OFF_FLAGS: begin
                    s_d.rdata[cfec_pkg::BIT_ERR_IRQ] = s_q.irq;
                    s_d.rdata[cfec_pkg::BIT_B0_RECOV] = s_q.b0;
                    if (wr && pwdata_i[cfec_pkg::BIT_ERR_IRQ]) begin
                        s_d.irq = 1'b0;
                    end
                    if (wr && pwdata_i[cfec_pkg::BIT_B0_RECOV]) begin
                        s_d.b0 = 1'b0;
                    end
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
            s_d.err = !hit;
        end
        // Queue head advance
        if (s_d.incr) begin
            s_d.qidx = (s_q.qidx == QLAST) ? '0 : s_q.qidx + QONE;
        end
        if (s_q.cfg) begin
            s_d.qidx = '0;
        end
        // Confinement state and recovery
        unique case (s_q.st)
            cfec_pkg::CFEC_ACTIVE: begin
                s_d.run = '0;
                s_d.seqs = '0;
                if (enter_bo) begin
                    s_d.st = cfec_pkg::CFEC_BUS_OFF;
                    s_d.irq = 1'b1;
                end
            end
            cfec_pkg::CFEC_BUS_OFF: begin
                if (s_q.cfg) begin
                    s_d.st = cfec_pkg::CFEC_ACTIVE;
                end else if (bit_tick_i) begin
                    if (!bus_recessive_i) begin
                        s_d.run = '0;
                    end else if (seq_done) begin
                        s_d.run = '0;
                        s_d.b0 = 1'b1;
                        s_d.seqs = s_q.seqs + 8'h01;
                        if (s_q.seqs == RECOVERY_SEQS - 8'h01) begin
                            s_d.st = cfec_pkg::CFEC_ACTIVE;
                            s_d.done = 1'b1;
                        end
                    end else begin
                        s_d.run = s_q.run + 4'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '{st: cfec_pkg::CFEC_ACTIVE,
                     cfg: cfec_pkg::CFG_MODE_RST,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata_o = s_q.rdata;
    assign pready_o = s_q.rdy;
    assign pslverr_o = s_q.err;
    assign config_mode_o = s_q.cfg;
    assign bus_off_o = s_q.st == cfec_pkg::CFEC_BUS_OFF;
    assign bus_error_irq_flag_o = s_q.irq;
    assign recovery_done_o = s_q.done;
    assign pointer_increment_o = s_q.incr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    logic rd_fault;
    assign rd_fault = rd && paddr_i == cfec_pkg::OFF_FAULT;

    property p_cfg_bus_off;
        rd_fault && s_q.cfg |=> prdata_o[cfec_pkg::BIT_BUS_OFF] && pready_o;
    endproperty
    a_cfg_bus_off: assert property (p_cfg_bus_off)
        else $error("bus-off bit clear in config mode");

    property p_enter_bo;
        enter_bo |=> bus_off_o && bus_error_irq_flag_o;
    endproperty
    a_enter_bo: assert property (p_enter_bo)
        else $error("bus-off not entered above limit");

    property p_irq_hold;
        enter_bo ##1 !(s_q.rdy && $past(wr)) |-> bus_error_irq_flag_o;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("error flag not raised on bus-off");

    property p_passive;
        rd_fault |=> prdata_o[cfec_pkg::BIT_TX_PASSIVE] ==
            $past(tx_error_count_i > 9'h07F) &&
            prdata_o[cfec_pkg::BIT_RX_PASSIVE] ==
            $past(rx_error_count_i > 8'h7F);
    endproperty
    a_passive: assert property (p_passive)
        else $error("passive bit wrong");

    property p_warn;
        rd_fault |=> prdata_o[cfec_pkg::BIT_TX_WARN] ==
            $past(tx_error_count_i > 9'h05F && tx_error_count_i < 9'h080);
    endproperty
    a_warn: assert property (p_warn)
        else $error("transmit warning bit wrong");

    property p_any_warn;
        rd_fault |=> prdata_o[cfec_pkg::BIT_ANY_WARN] ==
            (prdata_o[cfec_pkg::BIT_TX_WARN] ||
             prdata_o[cfec_pkg::BIT_RX_WARN]);
    endproperty
    a_any_warn: assert property (p_any_warn)
        else $error("any-warning bit is not the OR");

    property p_counts;
        rd_fault |=> prdata_o[15:8] == $past(tec8) &&
            prdata_o[7:0] == $past(rx_error_count_i);
    endproperty
    a_counts: assert property (p_counts)
        else $error("error count field wrong");

    property p_diag_clear;
        rd && paddr_i == cfec_pkg::OFF_DIAG
            |=> cnt_if[cfec_pkg::SLOT_NOM_RX].val <= 8'h01 ##1 !pready_o;
    endproperty
    a_diag_clear: assert property (p_diag_clear)
        else $error("diagnostics not cleared on read");

    property p_incr;
        wr && paddr_i == cfec_pkg::OFF_CTRL && !s_q.cfg &&
            pwdata_i[cfec_pkg::BIT_PTR_INCR] && s_q.qidx != QLAST
            |=> pointer_increment_o && s_q.qidx == $past(s_q.qidx) + QONE;
    endproperty
    a_incr: assert property (p_incr)
        else $error("queue head did not advance");

    property p_b0;
        bus_off_o && !s_q.cfg && bit_tick_i && bus_recessive_i && seq_done
            |=> s_q.b0 && s_q.run == 4'h0;
    endproperty
    a_b0: assert property (p_b0)
        else $error("recessive run not flagged");

    c_bus_off: cover property (enter_bo ##1 bus_off_o);
    c_recovered: cover property (recovery_done_o ##1 !bus_off_o);
    c_diag_read: cover property (rd && paddr_i == cfec_pkg::OFF_DIAG &&
        diag_w != 32'h0000_0000);
endmodule

//--- tb/cfec_bus_model.sv
// Far-side model: protocol engine counts and sampled bus bits
`timescale 1ns/1ns
module cfec_bus_model (
    input wire logic clk_i,
    output logic [8:0] tec_o,
    output logic [7:0] rec_o,
    output logic tick_o,
    output logic recessive_o,
    output logic [3:0] err_o
);
    initial begin
        tec_o = 9'h000;
        rec_o = 8'h00;
        tick_o = 1'b0;
        recessive_o = 1'b0;
        err_o = 4'h0;
    end
    // New counts from the engine
    task automatic set_counts(input logic [8:0] t, input logic [7:0] r);
        @(posedge clk_i);
        tec_o <= t;
        rec_o <= r;
    endtask
    // One-cycle error pulses on a slot
    task automatic pulse_err(input int slot, input int n);
        repeat (n) begin
            @(posedge clk_i);
            err_o[slot] <= 1'b1;
            @(posedge clk_i);
            err_o[slot] <= 1'b0;
        end
    endtask
    // Bit times; level off the tick is not valid
    task automatic bits(input logic lvl, input int n);
        repeat (n) begin
            @(posedge clk_i);
            tick_o <= 1'b1;
            recessive_o <= lvl;
            @(posedge clk_i);
            tick_o <= 1'b0;
            recessive_o <= ~lvl;
            repeat (2) @(posedge clk_i);
        end
    endtask
endmodule

//--- tb/cfec_top_tb_top.sv
// Self-checking bench for the fault-confinement status block
`timescale 1ns/1ns
module cfec_top_tb_top;
    localparam logic [31:0] BASE = 32'h0000_1000;
    localparam logic [31:0] ELEM = 32'h0000_0010;
    logic clk_i, rstn_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic pready_o, pslverr_o, cfg_o, boff_o, irq_o, done_o, incr_o, se;
    logic [8:0] tec;
    logic [7:0] rec;
    logic tick, recv;
    logic [3:0] err;
    int n_mismatch, comparisons, n_incr, n_done;
    logic [8:0] tt [0:6] = '{9'h000, 9'h05F, 9'h060, 9'h07F,
                             9'h080, 9'h0C8, 9'h0FF};
    logic [7:0] rr [0:6] = '{8'h00, 8'h60, 8'h5F, 8'h80,
                             8'h7F, 8'hFF, 8'h64};

    cfec_top #(.TXQ_BASE(BASE), .ELEM_BYTES(ELEM), .TXQ_DEPTH(8),
        .RECOVERY_SEQS(8'h02)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .tx_error_count_i(tec),
        .rx_error_count_i(rec), .bit_tick_i(tick),
        .bus_recessive_i(recv), .nom_rx_err_i(err[0]),
        .nom_tx_err_i(err[1]), .dat_rx_err_i(err[2]),
        .dat_tx_err_i(err[3]), .config_mode_o(cfg_o),
        .bus_off_o(boff_o), .bus_error_irq_flag_o(irq_o),
        .recovery_done_o(done_o), .pointer_increment_o(incr_o));
    cfec_bus_model bus (.clk_i(clk_i), .tec_o(tec), .rec_o(rec),
        .tick_o(tick), .recessive_o(recv), .err_o(err));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (incr_o === 1'b1) n_incr++;
        if (done_o === 1'b1) n_done++;
    end

    task automatic complete_run;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        chk("pready_o", 32'h1, {31'h0, pready_o});
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    function automatic logic [31:0] fexp(input logic [8:0] t,
        input logic [7:0] r, input logic bo);
        logic tw, rw;
        tw = (t > 9'h05F) && (t < 9'h080);
        rw = (r > 8'h5F) && (r < 8'h80);
        return {10'h000, bo, t > 9'h07F, r > 8'h7F, tw, rw, tw | rw,
            (t > 9'h0FF) ? 8'hFF : t[7:0], r};
    endfunction

    task automatic t_config;
        chk("config_mode_o", 32'h1, {31'h0, cfg_o});
        apb(1'b0, cfec_pkg::OFF_CTRL, 32'h0);
        chk("ctrl", 32'h1, rd);
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault cfg", 32'h0020_0000, rd);
        apb(1'b1, cfec_pkg::OFF_CTRL, 32'h3);
        @(posedge clk_i);
        chk("incr in cfg", 32'h0, 32'(n_incr));
        apb(1'b1, cfec_pkg::OFF_CTRL, 32'h0);
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault run", 32'h0, rd);
    endtask
    task automatic t_queue;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, cfec_pkg::OFF_TXQ_PTR, 32'h0);
            chk("queue ptr", BASE + 32'(i % 8) * ELEM, rd);
            apb(1'b1, cfec_pkg::OFF_CTRL, 32'h2);
        end
        // Let the pulse counter see the last pulse
        @(posedge clk_i);
        chk("incr pulses", 32'h9, 32'(n_incr));
    endtask
    task automatic t_faults;
        logic [31:0] e;
        for (int i = 0; i < 7; i++) begin
            bus.set_counts(tt[i], rr[i]);
            apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
            e = fexp(tt[i], rr[i], 1'b0);
            chk("fault", e, rd);
        end
        chk("bus_off_o at 255", 32'h0, {31'h0, boff_o});
    endtask
    task automatic t_bus_off;
        bus.set_counts(9'h12C, 8'h00);
        repeat (3) @(posedge clk_i);
        chk("bus_off_o", 32'h1, {31'h0, boff_o});
        chk("irq flag", 32'h1, {31'h0, irq_o});
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault boff", fexp(9'h12C, 8'h00, 1'b1), rd);
        bus.set_counts(9'h000, 8'h00);
        bus.bits(1'b1, 10);
        bus.bits(1'b0, 1);
        bus.bits(1'b1, 10);
        apb(1'b0, cfec_pkg::OFF_FLAGS, 32'h0);
        chk("flags broken run", 32'h1, rd);
        bus.bits(1'b1, 1);
        apb(1'b0, cfec_pkg::OFF_FLAGS, 32'h0);
        chk("flags run", 32'h3, rd);
        apb(1'b1, cfec_pkg::OFF_FLAGS, 32'h3);
        apb(1'b0, cfec_pkg::OFF_FLAGS, 32'h0);
        chk("flags cleared", 32'h0, rd);
        chk("still off", 32'h1, {31'h0, boff_o});
        bus.bits(1'b1, 11);
        repeat (3) @(posedge clk_i);
        chk("done pulses", 32'h1, 32'(n_done));
        chk("bus_off_o end", 32'h0, {31'h0, boff_o});
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault end", 32'h0, rd);
    endtask
    task automatic t_diag;
        apb(1'b0, cfec_pkg::OFF_DIAG, 32'h0);
        chk("diag idle", 32'h0, rd);
        for (int s = 0; s < 4; s++) begin
            bus.pulse_err(s, s + 1);
        end
        apb(1'b0, cfec_pkg::OFF_DIAG, 32'h0);
        chk("diag", 32'h0403_0201, rd);
        apb(1'b0, cfec_pkg::OFF_DIAG, 32'h0);
        chk("diag cleared", 32'h0, rd);
        bus.pulse_err(1, 260);
        apb(1'b0, cfec_pkg::OFF_DIAG, 32'h0);
        chk("diag sat", 32'h0000_FF00, rd);
    endtask
    task automatic t_refuse;
        apb(1'b1, cfec_pkg::OFF_FAULT, 32'hFFFF_FFFF);
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault ro", 32'h0, rd);
        chk("slverr ok", 32'h0, {31'h0, se});
        apb(1'b0, 12'h014, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped err", 32'h1, {31'h0, se});
        apb(1'b1, cfec_pkg::OFF_CTRL, 32'h1);
        apb(1'b0, cfec_pkg::OFF_FAULT, 32'h0);
        chk("fault recfg", 32'h0020_0000, rd);
    endtask

    initial begin
        rstn_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        repeat (5) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_config;
        t_queue;
        t_faults;
        t_bus_off;
        t_diag;
        t_refuse;
        complete_run;
    end
    initial begin
        repeat (6000) @(posedge clk_i);
        n_mismatch++;
        complete_run;
    end
endmodule
